// ===== logic/pbc_defines.svh
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

// ==========================================================
// Register byte offsets (low address bits decoded)
`define PBC_DEC_W 12
`define PBC_OFS_HDR 12'h280
`define PBC_OFS_SEL 12'h284
`define PBC_OFS_WIN 12'h288
`define PBC_OFS_FLAG 12'h28c
`define PBC_OFS_VAL 12'h300
`define PBC_OFS_SYSCTL 12'h340
`define PBC_ALIGN_MASK 12'hffc
`define PBC_WORD_BYTES 12'h004

// ==========================================================
// Counts, widths and values
`define PBC_NUM_VAL 10
`define PBC_MAX_VAL 16
`define PBC_SEL_W 8
`define PBC_SEL_MAX 8'h09
`define PBC_STRUCTURE_IDENTIFIER_PWRB 16'h0004
`define PBC_STRUCTURE_VERSION_ONE 4'h1
`define PBC_RST_WORD 32'h0000_0000
`define PBC_HRESP_OKAY 1'b0

`endif

// ===== logic/pbc_pkg.sv
package pbc_pkg;

  // ========================================================
  // Capability header word layout
  typedef struct packed {
    logic [11:0] next_structure_pointer;
    logic [3:0] structure_version;
    logic [15:0] structure_identifier;
  } pbc_header_s;

  // ========================================================
  // Configuration loader write port
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] data;
  } pbc_load_s;

endpackage

// ===== logic/pbc_regs.sv
// Summary of operation
// [RL1] Header holds identifier and next pointer, reset zero
// [RL2] Header holds four-bit structure version field
// [RL3] Eight-bit select field picks reported value
// [RL4] Select above nine reads window as zero
// [RL5] Window returns selected value, else zero
// [RL6] Sticky system-allocated flag, resets to zero
// [RL7] Loader fills identifier, version, flag from EEPROM
// [RL8] Ten sticky values bus-writable only when unlocked
// [RL9] Loader writes despite lock, dropped in a hot reset cycle; sticky survives hot reset
`timescale 1ns/1ps

`include "pbc_defines.svh"

module pbc_regs
  import pbc_pkg::*;
#(
  parameter int NUM_VAL = `PBC_NUM_VAL
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hot_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire pbc_load_s load_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic system_allocated_out,
  output logic value_write_unlock_out
);

  // ========================================================
  // Parameter check
  if (NUM_VAL < 1 || NUM_VAL > `PBC_MAX_VAL) begin : g_chk
    $error("pbc_regs: NUM_VAL out of range");
  end

  // ========================================================
  // State
  typedef struct packed {
    pbc_header_s hdr;
    logic [`PBC_SEL_W-1:0] value_select_field;
    logic system_allocated_flag;
    logic value_write_unlock;
    logic [NUM_VAL-1:0][31:0] vals;
    logic wpend;
    logic [11:0] waddr;
    logic stall;
    logic [11:0] raddr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } pbc_state_s;

  localparam pbc_state_s STATE_RST = '{
    hdr: `PBC_RST_WORD,
    value_select_field: '0,
    system_allocated_flag: 1'b0,
    value_write_unlock: 1'b0,
    vals: '0,
    wpend: 1'b0,
    waddr: '0,
    stall: 1'b0,
    raddr: '0,
    hrdata: `PBC_RST_WORD,
    hready: 1'b1,
    hresp: `PBC_HRESP_OKAY
  };

  pbc_state_s s_q;
  pbc_state_s s_d;
  logic [31:0] win_w;
  logic acc_w;

  // ========================================================
  // Helpers
  function automatic logic [11:0] val_ofs(input int i);
    val_ofs = 12'(`PBC_OFS_VAL + i * `PBC_WORD_BYTES);
  endfunction

  function automatic logic [31:0] window(input pbc_state_s s);
    window = `PBC_RST_WORD;
    for (int i = 0; i < NUM_VAL; i++) begin
      if (s.value_select_field == 8'(i)) begin
        window = s.vals[i]; // RL5
      end
    end
  endfunction

  function automatic logic [31:0] read_word(input pbc_state_s s,
                                            input logic [11:0] a);
    logic [11:0] al;
    al = a & `PBC_ALIGN_MASK;
    read_word = `PBC_RST_WORD;
    case (al)
      `PBC_OFS_HDR: read_word = s.hdr; // RL1
      `PBC_OFS_SEL: read_word[`PBC_SEL_W-1:0] = s.value_select_field;
      `PBC_OFS_WIN: read_word = window(s); // RL4
      `PBC_OFS_FLAG: read_word[0] = s.system_allocated_flag; // RL6
      `PBC_OFS_SYSCTL: read_word[0] = s.value_write_unlock;
      default: begin
        for (int i = 0; i < NUM_VAL; i++) begin
          if (al == val_ofs(i)) begin
            read_word = s.vals[i];
          end
        end
      end
    endcase
  endfunction

  function automatic pbc_state_s write_word(input pbc_state_s s,
                                            input logic [11:0] a,
                                            input logic [31:0] d,
                                            input logic loader);
    logic [11:0] al;
    logic ok;
    al = a & `PBC_ALIGN_MASK;
    ok = loader | s.value_write_unlock; // RL9
    write_word = s;
    case (al)
      `PBC_OFS_HDR: begin
        if (ok) begin
          write_word.hdr = pbc_header_s'(d); // RL1 RL2 RL7
        end
      end
      `PBC_OFS_SEL: begin
        write_word.value_select_field = d[`PBC_SEL_W-1:0]; // RL3
      end
      `PBC_OFS_FLAG: begin
        if (ok) begin
          write_word.system_allocated_flag = d[0]; // RL6
        end
      end
      `PBC_OFS_SYSCTL: begin
        write_word.value_write_unlock = d[0];
      end
      default: begin
        for (int i = 0; i < NUM_VAL; i++) begin
          if (ok && al == val_ofs(i)) begin
            write_word.vals[i] = d; // RL8
          end
        end
      end
    endcase
  endfunction

  // ========================================================
  // Next state
  assign acc_w = hsel_in & hready_in & htrans_in[1];
  assign win_w = window(s_q);

  always_comb begin
    s_d = s_q;
    s_d.wpend = 1'b0;
    if (s_q.wpend) begin
      s_d = write_word(s_d, s_q.waddr, hwdata_in, 1'b0);
    end
    if (s_q.stall) begin
      s_d.hrdata = read_word(s_q, s_q.raddr);
      s_d.hready = 1'b1;
      s_d.stall = 1'b0;
    end
    if (acc_w) begin
      if (hwrite_in) begin
        s_d.wpend = 1'b1;
        s_d.waddr = haddr_in[`PBC_DEC_W-1:0];
      end else if (s_q.wpend) begin
        // Read right behind a write waits one cycle
        s_d.stall = 1'b1;
        s_d.hready = 1'b0;
        s_d.raddr = haddr_in[`PBC_DEC_W-1:0];
      end else begin
        s_d.hrdata = read_word(s_q, haddr_in[`PBC_DEC_W-1:0]);
      end
    end
    if (load_in.wr) begin
      s_d = write_word(s_d, load_in.addr, load_in.data, 1'b1); // RL9
    end
    if (hot_rst_in) begin
      // Hot reset keeps sticky fields only
      s_d = STATE_RST; // RL9
      s_d.system_allocated_flag = s_q.system_allocated_flag; // RL6
      s_d.vals = s_q.vals; // RL8
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_out = s_q.hrdata;
  assign hreadyout_out = s_q.hready;
  assign hresp_out = s_q.hresp;
  assign system_allocated_out = s_q.system_allocated_flag;
  assign value_write_unlock_out = s_q.value_write_unlock;

  // ========================================================
  // Checks
  logic rd_hdr_w;
  logic rd_win_w;
  logic wr_quiet_w;
  assign rd_hdr_w = acc_w & ~hwrite_in & ~s_q.wpend &
    ((haddr_in[`PBC_DEC_W-1:0] & `PBC_ALIGN_MASK) == `PBC_OFS_HDR);
  assign rd_win_w = acc_w & ~hwrite_in & ~s_q.wpend &
    ((haddr_in[`PBC_DEC_W-1:0] & `PBC_ALIGN_MASK) == `PBC_OFS_WIN);
  assign wr_quiet_w = s_q.wpend & ~load_in.wr & ~hot_rst_in;

  property p_hdr_read;
    @(posedge clock_in) disable iff (rst_in)
    rd_hdr_w && !hot_rst_in |=> hrdata_out == $past(s_q.hdr);
  endproperty
  a_hdr_read: assert property (p_hdr_read) // RL1
    else $error("header read mismatch");

  property p_version_write;
    @(posedge clock_in) disable iff (rst_in)
    wr_quiet_w && s_q.value_write_unlock &&
    (s_q.waddr & `PBC_ALIGN_MASK) == `PBC_OFS_HDR
    |=> s_q.hdr == pbc_header_s'($past(hwdata_in));
  endproperty
  a_version_write: assert property (p_version_write) // RL2
    else $error("version field not written");

  property p_select_write;
    @(posedge clock_in) disable iff (rst_in)
    wr_quiet_w && (s_q.waddr & `PBC_ALIGN_MASK) == `PBC_OFS_SEL
    |=> s_q.value_select_field == $past(hwdata_in[`PBC_SEL_W-1:0]);
  endproperty
  a_select_write: assert property (p_select_write) // RL3
    else $error("select field not written");

  property p_window_zero;
    @(posedge clock_in) disable iff (rst_in)
    s_q.value_select_field > `PBC_SEL_MAX |-> win_w == `PBC_RST_WORD;
  endproperty
  a_window_zero: assert property (p_window_zero) // RL4
    else $error("window not zero for large select");

  property p_window_read;
    @(posedge clock_in) disable iff (rst_in)
    rd_win_w && !hot_rst_in |=> hrdata_out ==
      ($past(s_q.value_select_field) < NUM_VAL ?
       $past(s_q.vals[s_q.value_select_field]) : `PBC_RST_WORD);
  endproperty
  a_window_read: assert property (p_window_read) // RL5
    else $error("window read mismatch");

  property p_sa_sticky;
    @(posedge clock_in) disable iff (rst_in)
    hot_rst_in |=> system_allocated_out == $past(system_allocated_out)
                   && !value_write_unlock_out;
  endproperty
  a_sa_sticky: assert property (p_sa_sticky) // RL6
    else $error("allocated flag lost on hot reset");

  property p_sa_reset;
    @(posedge clock_in)
    rst_in |=> !system_allocated_out && s_q.hdr == `PBC_RST_WORD;
  endproperty
  a_sa_reset: assert property (p_sa_reset) // RL6
    else $error("fundamental reset did not clear");

  property p_val_locked;
    @(posedge clock_in) disable iff (rst_in)
    wr_quiet_w && !s_q.value_write_unlock
    |=> $stable(s_q.vals) [*1] ##0 $stable(s_q.hdr);
  endproperty
  a_val_locked: assert property (p_val_locked) // RL8
    else $error("locked register was written");

  property p_loader_write;
    @(posedge clock_in) disable iff (rst_in)
    load_in.wr && !hot_rst_in && !value_write_unlock_out &&
    (load_in.addr & `PBC_ALIGN_MASK) == val_ofs(0)
    |=> s_q.vals[0] == $past(load_in.data);
  endproperty
  a_loader_write: assert property (p_loader_write) // RL9
    else $error("loader write dropped");

  property p_hot_clear;
    @(posedge clock_in) disable iff (rst_in)
    hot_rst_in |=> s_q.hdr == `PBC_RST_WORD &&
      s_q.value_select_field == '0 && s_q.vals == $past(s_q.vals);
  endproperty
  a_hot_clear: assert property (p_hot_clear) // RL9
    else $error("hot reset handling wrong");

  property p_stall;
    @(posedge clock_in) disable iff (rst_in)
    acc_w && !hwrite_in && s_q.wpend && !hot_rst_in
    |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_stall: assert property (p_stall)
    else $error("read after write not stalled once");

  property p_okay;
    @(posedge clock_in) disable iff (rst_in)
    hresp_out == `PBC_HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");

  c_window_valid: cover property (@(posedge clock_in)
    rd_win_w && s_q.value_select_field < NUM_VAL);
  c_stall: cover property (@(posedge clock_in)
    acc_w && !hwrite_in && s_q.wpend);
  c_locked_drop: cover property (@(posedge clock_in)
    wr_quiet_w && !s_q.value_write_unlock);
  c_pwrb_id: cover property (@(posedge clock_in)
    s_q.hdr.structure_identifier == `PBC_STRUCTURE_IDENTIFIER_PWRB &&
    s_q.hdr.structure_version == `PBC_STRUCTURE_VERSION_ONE);

endmodule

// ===== tb/pbc_regs_bench.sv
`timescale 1ns/1ps

module pbc_regs_bench;
  import pbc_pkg::*;

  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic hot_rst_in = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  pbc_load_s load = '0;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  logic sys_alloc;
  logic unlock;
  logic [31:0] q[$];
  logic [31:0] v[10];
  logic [11:0] adr[8] = '{12'h280, 12'h284, 12'h288, 12'h28c,
                          12'h300, 12'h324, 12'h340, 12'h200};
  logic rd_pend = 1'b0;
  logic [31:0] x;
  logic [31:0] h;
  logic [7:0] sel;
  int errors = 0;
  int tests_run = 0;

  always #5 clock_in = ~clock_in;

  pbc_regs #(.NUM_VAL(10)) dut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .hot_rst_in(hot_rst_in),
    .hsel_in(hsel),
    .haddr_in(haddr),
    .htrans_in(htrans),
    .hwrite_in(hwrite),
    .hsize_in(3'h2),
    .hwdata_in(hwdata),
    .hready_in(hreadyout_out),
    .load_in(load),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .system_allocated_out(sys_alloc),
    .value_write_unlock_out(unlock)
  );

  // ========================================================
  // Checking and closing
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task end_sim;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ========================================================
  // Bus master
  task waitrdy;
    int n;
    n = 0;
    @(posedge clock_in);
    while (hreadyout_out !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        end_sim;
      end
      @(posedge clock_in);
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    waitrdy;
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task ld(input logic [11:0] a, input logic [31:0] d);
    load <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clock_in);
    load.wr <= 1'b0;
    @(posedge clock_in);
  endtask

  // ========================================================
  // Read data monitor
  always @(posedge clock_in) begin
    if (rd_pend && hreadyout_out === 1'b1) begin
      rd_pend = 1'b0;
      chk("hresp", {31'h0, hresp_out}, 32'h0);
      if (q.size() == 0) begin
        chk("queue", 32'h0, 32'h1);
      end else begin
        chk("hrdata", hrdata_out, q.pop_front());
      end
    end
    if (!rst_in && !hot_rst_in && hsel && htrans[1] &&
        hreadyout_out === 1'b1) begin
      rd_pend = !hwrite;
    end
  end

  // ========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h4892c9eb));
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    foreach (adr[i]) rd(adr[i], 32'h0);
    // Locked writes are dropped
    wr(12'h280, 32'hffffffff);
    wr(12'h28c, 32'h1);
    wr(12'h300, 32'h5a5a5a5a);
    wr(12'h288, 32'h1234);
    rd(12'h280, 32'h0);
    rd(12'h28c, 32'h0);
    rd(12'h300, 32'h0);
    rd(12'h288, 32'h0);
    // Loader fills header, flag and a value
    x = $urandom;
    h = {x[11:0], 4'h1, 16'h0004};
    v[3] = $urandom;
    ld(12'h280, h);
    ld(12'h28c, 32'h1);
    ld(12'h30c, v[3]);
    rd(12'h280, h);
    rd(12'h30c, v[3]);
    chk("sys_alloc", {31'h0, sys_alloc}, 32'h1);
    // Unlock and fill every value
    wr(12'h340, 32'h1);
    rd(12'h340, 32'h1);
    chk("unlock", {31'h0, unlock}, 32'h1);
    for (int i = 0; i < 10; i++) begin
      v[i] = $urandom;
      wr(12'h300 + 12'(4 * i), v[i]);
    end
    for (int s = 0; s < 14; s++) begin
      sel = (s == 13) ? 8'hff : 8'(s);
      x = $urandom;
      wr(12'h284, {x[31:8], sel});
      rd(12'h284, {24'h0, sel});
      rd(12'h288, (sel < 8'h0a) ? v[sel] : 32'h0);
    end
    // Flag by software, reserved bits zero
    wr(12'h28c, 32'hfffffffe);
    rd(12'h28c, 32'h0);
    chk("sys_alloc", {31'h0, sys_alloc}, 32'h0);
    wr(12'h28c, 32'hffffffff);
    rd(12'h28c, 32'h1);
    // Hot reset keeps sticky state only
    hot_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    hot_rst_in <= 1'b0;
    @(posedge clock_in);
    rd(12'h28c, 32'h1);
    rd(12'h280, 32'h0);
    rd(12'h284, 32'h0);
    rd(12'h340, 32'h0);
    rd(12'h288, v[0]);
    rd(12'h324, v[9]);
    chk("unlock", {31'h0, unlock}, 32'h0);
    chk("sys_alloc", {31'h0, sys_alloc}, 32'h1);
    // Deselected transfer is ignored
    hsel <= 1'b0;
    wr(12'h284, 32'h5);
    hsel <= 1'b1;
    rd(12'h284, 32'h0);
    // Loader ignores the lock
    x = $urandom;
    ld(12'h304, x);
    rd(12'h304, x);
    // Fundamental reset clears sticky state
    rst_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rd(12'h28c, 32'h0);
    rd(12'h304, 32'h0);
    chk("sys_alloc", {31'h0, sys_alloc}, 32'h0);
    end_sim;
  end
endmodule
